// *** rtl/irc_pkg.sv ***
/*
  Constants for the interrupt enable and reset cause register bank:
  byte offsets, field positions, write masks and reset values.
  Assumes a 32-bit Avalon-MM slave whose registers sit in the low byte.
*/
package irc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PWR = 8'h0c;
  localparam logic [7:0] OFF_PIE = 8'h8c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_CLR = 8'h18;
  localparam logic [7:0] OFF_EN = 8'h1c;
  localparam logic [7:0] OFF_PEND = 8'h20;
  // ----------------------------------------------------------------
  // Interrupt enable fields
  // ----------------------------------------------------------------
  localparam int PIE_EEPROM = 7;
  localparam int PIE_CMP = 6;
  localparam int PIE_RX = 5;
  localparam int PIE_TX = 4;
  localparam int PIE_CCP = 2;
  localparam int PIE_TMR2 = 1;
  localparam int PIE_TMR1 = 0;
  localparam logic [7:0] PIE_WMASK = 8'hf7;
  localparam logic [7:0] PIE_RST = 8'h00;
  // ----------------------------------------------------------------
  // Power control fields
  // ----------------------------------------------------------------
  localparam int PWR_OSC = 3;
  localparam int PWR_POR = 1;
  localparam int PWR_BRN = 0;
  localparam logic OSC_RST = 1'b1;
  localparam logic POR_RST = 1'b0;
  localparam logic BRN_RST = 1'b0;
  // ----------------------------------------------------------------
  // Control, event status fields
  // ----------------------------------------------------------------
  localparam int CTRL_GLOBAL = 0;
  localparam int CTRL_GROUP = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int EVT_BROWNOUT = 0;
  localparam int EVT_OTHER_RST = 1;
  localparam int EVT_CORE_IRQ = 2;
  localparam int EVT_W = 3;
  localparam logic [2:0] EVT_RST = 3'h0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IRC_OSC_SLOW = 2'b00,
    IRC_OSC_FAST = 2'b01,
    IRC_OSC_RES = 2'b10
  } irc_osc_e;
  typedef enum logic {
    IRC_BUS_IDLE = 1'b0,
    IRC_BUS_ACK = 1'b1
  } irc_bus_e;
endpackage : irc_pkg

// *** rtl/irc_sync3.sv ***
/*
  Three-flop synchroniser for an asynchronous pin.
  Assumes the pin holds each level for several clocks.
*/
`timescale 1ns/1ps
module irc_sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin and clean level
  input wire logic pin,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // ----------------------------------------------------------------
  // Chain
  // ----------------------------------------------------------------
  // Only agreed samples move the level, rejecting a late settle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level = level_reg;
endmodule : irc_sync3

// *** rtl/irc_irq_gate.sv ***
/*
  Per-source interrupt masking with group and global gates.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module irc_irq_gate #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Requests and enables
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] enable,
  input wire logic group_en,
  input wire logic global_en,
  // Results
  output logic [N-1:0] pending,
  output logic core_irq
);
  logic [N-1:0] pending_reg;
  logic core_irq_reg;

  // ----------------------------------------------------------------
  // Gating
  // ----------------------------------------------------------------
  // Pending flags are masked by enable only; group and global gates act on the forwarded request alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pending_reg <= '0;
      core_irq_reg <= 1'b0;
    end else begin
      pending_reg <= req & enable;
      core_irq_reg <= (|(req & enable)) & group_en & global_en;
    end
  end

  assign pending = pending_reg;
  assign core_irq = core_irq_reg;
endmodule : irc_irq_gate

// *** rtl/irc_regs.sv ***
/*
  Interrupt enable and reset cause register bank, Avalon-MM slave.
  Assumes a master that holds each request until waitrequest is low,
  same-clock peripheral requests and asynchronous reset-cause pins.
*/
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module irc_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Peripheral requests
  input wire logic [7:0] periph_irq_req,
  output logic core_irq,
  // Reset causes
  input wire logic brownout_reset_pin,
  input wire logic other_reset_pin,
  input wire logic brownout_detect_enable_cfg,
  // Oscillator
  input wire logic external_resistor_osc_mode,
  output logic osc_speed_select,
  output logic [1:0] osc_rate_sel,
  // Interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  irc_pkg::irc_bus_e bus_state_reg;
  logic wait_reg;
  logic [31:0] readdata_reg;
  logic [31:0] rd_next;
  logic wr_fire;
  logic be_lo;
  logic [7:0] wbyte;
  logic [7:0] pie_reg;
  logic osc_reg;
  logic por_reg;
  logic brn_flag_reg;
  logic [1:0] ctrl_reg;
  logic [2:0] stat_reg;
  logic [2:0] en_reg;
  logic [2:0] evt;
  logic irq_reg;
  logic [1:0] rate_reg;
  logic [7:0] pending;
  logic core_irq_w;
  logic core_irq_d;
  logic bo_lvl;
  logic bo_lvl_d;
  logic ot_lvl;
  logic ot_lvl_d;
  logic bo_evt;
  logic ot_evt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] data,
                                          input logic [7:0] mask);
    wr_merge = (old & ~mask) | (data & mask);
  endfunction : wr_merge

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait state gives a clean registered read path
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_reg <= irc_pkg::IRC_BUS_IDLE;
      wait_reg <= 1'b1;
    end else begin
      unique case (bus_state_reg)
        irc_pkg::IRC_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_reg <= irc_pkg::IRC_BUS_ACK;
            wait_reg <= 1'b0;
          end
        end
        irc_pkg::IRC_BUS_ACK: begin
          bus_state_reg <= irc_pkg::IRC_BUS_IDLE;
          wait_reg <= 1'b1;
        end
      endcase
    end
  end

  assign wr_fire = (bus_state_reg == irc_pkg::IRC_BUS_ACK) && avs_write;
  assign be_lo = avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped and write-only offsets read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit(avs_address, irc_pkg::OFF_PIE)) begin
      rd_next[7:0] = pie_reg & irc_pkg::PIE_WMASK;
    end else if (hit(avs_address, irc_pkg::OFF_PWR)) begin
      rd_next[irc_pkg::PWR_OSC] = osc_reg;
      rd_next[irc_pkg::PWR_POR] = por_reg;
      rd_next[irc_pkg::PWR_BRN] = brn_flag_reg;
    end else if (hit(avs_address, irc_pkg::OFF_CTRL)) begin
      rd_next[1:0] = ctrl_reg;
    end else if (hit(avs_address, irc_pkg::OFF_STAT)) begin
      rd_next[2:0] = stat_reg;
    end else if (hit(avs_address, irc_pkg::OFF_EN)) begin
      rd_next[2:0] = en_reg;
    end else if (hit(avs_address, irc_pkg::OFF_PEND)) begin
      rd_next[7:0] = pending;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (bus_state_reg == irc_pkg::IRC_BUS_IDLE && avs_read) begin
      readdata_reg <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pie_reg <= irc_pkg::PIE_RST;
    end else if (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_PIE)) begin
      pie_reg <= wr_merge(8'h00, wbyte, irc_pkg::PIE_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // Group and global enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= irc_pkg::CTRL_RST;
    end else if (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_CTRL)) begin
      ctrl_reg <= wbyte[1:0];
    end
  end

  irc_irq_gate #(
    .N(8)
  ) u_gate (
    .clk(clk),
    .nrst(nrst),
    .req(periph_irq_req),
    .enable(pie_reg),
    .group_en(ctrl_reg[irc_pkg::CTRL_GROUP]),
    .global_en(ctrl_reg[irc_pkg::CTRL_GLOBAL]),
    .pending(pending),
    .core_irq(core_irq_w)
  );

  // ----------------------------------------------------------------
  // Reset cause pins
  // ----------------------------------------------------------------
  irc_sync3 u_sync_bo (
    .clk(clk),
    .nrst(nrst),
    .pin(brownout_reset_pin),
    .level(bo_lvl)
  );

  irc_sync3 u_sync_ot (
    .clk(clk),
    .nrst(nrst),
    .pin(other_reset_pin),
    .level(ot_lvl)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bo_lvl_d <= 1'b0;
      ot_lvl_d <= 1'b0;
      core_irq_d <= 1'b0;
    end else begin
      bo_lvl_d <= bo_lvl;
      ot_lvl_d <= ot_lvl;
      core_irq_d <= core_irq_w;
    end
  end

  assign bo_evt = bo_lvl && !bo_lvl_d;
  assign ot_evt = ot_lvl && !ot_lvl_d;

  // ----------------------------------------------------------------
  // Power control and reset cause
  // ----------------------------------------------------------------
  // Power-on is nrst itself, so the power-on flag is simply its reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      por_reg <= irc_pkg::POR_RST;
    end else if (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_PWR)) begin
      por_reg <= wbyte[irc_pkg::PWR_POR];
    end
  end

  // Reset cause wins over a software write in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brn_flag_reg <= irc_pkg::BRN_RST;
    end else if (bo_evt && brownout_detect_enable_cfg) begin
      brn_flag_reg <= 1'b0;
    end else if (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_PWR)) begin
      brn_flag_reg <= wbyte[irc_pkg::PWR_BRN];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_reg <= irc_pkg::OSC_RST;
    end else if (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_PWR)) begin
      osc_reg <= wbyte[irc_pkg::PWR_OSC];
    end
  end

  // ----------------------------------------------------------------
  // Oscillator rate select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_reg <= irc_pkg::IRC_OSC_FAST;
    end else if (!osc_reg) begin
      rate_reg <= irc_pkg::IRC_OSC_SLOW;
    end else if (external_resistor_osc_mode) begin
      rate_reg <= irc_pkg::IRC_OSC_RES;
    end else begin
      rate_reg <= irc_pkg::IRC_OSC_FAST;
    end
  end

  // ----------------------------------------------------------------
  // Event status, enable, interrupt
  // ----------------------------------------------------------------
  assign evt = {core_irq_w && !core_irq_d, ot_evt, bo_evt && brownout_detect_enable_cfg};

  // A set in the clearing cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= irc_pkg::EVT_RST;
    end else if (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_CLR)) begin
      stat_reg <= (stat_reg & ~wbyte[2:0]) | evt;
    end else begin
      stat_reg <= stat_reg | evt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_reg <= irc_pkg::EVT_RST;
    end else if (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_EN)) begin
      en_reg <= wbyte[2:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & en_reg);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign core_irq = core_irq_w;
  assign osc_speed_select = osc_reg;
  assign osc_rate_sel = rate_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  pie_unimpl_zero_a: assert property (pie_reg[3] == 1'b0)
    else $error("enable bit 3 not zero");

  pie_write_lands_a: assert property (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_PIE)
    |=> pie_reg == ($past(wbyte) & irc_pkg::PIE_WMASK))
    else $error("enable write lost");

  mask_gates_req_a: assert property (##1 pending == ($past(periph_irq_req) & $past(pie_reg)))
    else $error("masking wrong");

  core_irq_cause_a: assert property (core_irq |-> $past(ctrl_reg) == 2'h3
    && $past(|(periph_irq_req & pie_reg)))
    else $error("core irq without cause");

  brn_clear_a: assert property (bo_evt && brownout_detect_enable_cfg |=> !brn_flag_reg)
    else $error("brownout flag not cleared");

  por_hold_a: assert property (!(wr_fire && hit(avs_address, irc_pkg::OFF_PWR))
    |=> $stable(por_reg))
    else $error("power-on flag moved");

  other_rst_cause_a: assert property (ot_evt && !bo_evt && !wr_fire
    |=> stat_reg[irc_pkg::EVT_OTHER_RST] && $stable(brn_flag_reg) && $stable(por_reg))
    else $error("other reset confused");

  brn_sw_set_a: assert property (wr_fire && be_lo && hit(avs_address, irc_pkg::OFF_PWR)
    && wbyte[irc_pkg::PWR_BRN] && !bo_evt |=> brn_flag_reg)
    else $error("brownout flag not set");

  brn_disabled_a: assert property (bo_evt && !brownout_detect_enable_cfg && !wr_fire
    |=> $stable(brn_flag_reg))
    else $error("disabled brownout moved flag");

  osc_rate_a: assert property (osc_reg && external_resistor_osc_mode
    |=> osc_rate_sel == irc_pkg::IRC_OSC_RES)
    else $error("resistor rate not chosen");

  osc_slow_a: assert property (!osc_reg |=> osc_rate_sel == irc_pkg::IRC_OSC_SLOW)
    else $error("slow rate not chosen");

  pwr_read_zero_a: assert property (bus_state_reg == irc_pkg::IRC_BUS_IDLE && avs_read
    && hit(avs_address, irc_pkg::OFF_PWR) |=> readdata_reg[7:4] == 4'h0
    && readdata_reg[2] == 1'b0)
    else $error("unimplemented bits set");

  cov_pie_write: cover property (wr_fire && hit(avs_address, irc_pkg::OFF_PIE));
  cov_brownout: cover property (bo_evt ##1 !brn_flag_reg);
  cov_core_irq: cover property (core_irq);
  cov_irq_out: cover property (irq ##[1:4] !irq);
endmodule : irc_regs

// *** bench/irc_regs_tb.sv ***
/*
  Self-checking bench for the interrupt enable and reset cause register bank.
  Assumes the bank answers each Avalon-MM request by dropping waitrequest,
  and the reset-cause pins pass a multi-flop synchroniser.
*/
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk;
  logic nrst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] periph_irq_req;
  logic core_irq;
  logic brownout_reset_pin;
  logic other_reset_pin;
  logic brownout_detect_enable_cfg;
  logic external_resistor_osc_mode;
  logic osc_speed_select;
  logic [1:0] osc_rate_sel;
  logic irq;
  int errors;
  int checked;
  int cycles;
  logic [31:0] rd;

  irc_regs DUT (
    .clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_irq_req(periph_irq_req), .core_irq(core_irq),
    .brownout_reset_pin(brownout_reset_pin), .other_reset_pin(other_reset_pin),
    .brownout_detect_enable_cfg(brownout_detect_enable_cfg),
    .external_resistor_osc_mode(external_resistor_osc_mode),
    .osc_speed_select(osc_speed_select), .osc_rate_sel(osc_rate_sel), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run needs well under 2000 cycles
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles >= 5000) begin
        errors++;
        $display("Error at %0t: run did not finish in time", $time);
        end_sim();
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Sampling at the edge sees the value from before that edge's updates
  // No wait limit here; a bank that never answers runs into the timeout
  task automatic wait_ack();
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
  endtask : wait_ack

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read

  task automatic read_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus_read(a, rd);
    chk(rd, exp, what);
  endtask : read_chk

  // Pin held long enough to pass the synchroniser, then left to settle
  task automatic pulse_pin(input bit brownout);
    @(posedge clk);
    if (brownout) begin
      brownout_reset_pin <= 1'b1;
    end else begin
      other_reset_pin <= 1'b1;
    end
    repeat (8) @(posedge clk);
    brownout_reset_pin <= 1'b0;
    other_reset_pin <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse_pin

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    read_chk(irc_pkg::OFF_PIE, 32'h00000000, "enable reset");
    read_chk(irc_pkg::OFF_PWR, 32'h00000008, "power ctrl reset");
    chk({31'h0, osc_speed_select}, 32'h1, "speed out reset");
    chk({30'h0, osc_rate_sel}, {30'h0, irc_pkg::IRC_OSC_FAST}, "rate reset");
    chk({30'h0, core_irq, irq}, 32'h0, "irq outputs reset");
  endtask : test_reset_values

  task automatic test_enable_bits();
    bus_write(irc_pkg::OFF_PIE, 8'hff);
    read_chk(irc_pkg::OFF_PIE, 32'h000000f7, "enable all");
    bus_write(irc_pkg::OFF_PIE, 8'h08);
    read_chk(irc_pkg::OFF_PIE, 32'h00000000, "enable bit three");
    bus_write(irc_pkg::OFF_PIE, 8'h5a, 4'h0);
    read_chk(irc_pkg::OFF_PIE, 32'h00000000, "byte lane off");
    bus_write(8'h44, 8'hff);
    read_chk(8'h44, 32'h00000000, "unmapped read");
  endtask : test_enable_bits

  task automatic test_masking();
    int srcs[7] = '{irc_pkg::PIE_EEPROM, irc_pkg::PIE_CMP, irc_pkg::PIE_RX, irc_pkg::PIE_TX,
                    irc_pkg::PIE_CCP, irc_pkg::PIE_TMR2, irc_pkg::PIE_TMR1};
    logic [7:0] one;
    bus_write(irc_pkg::OFF_CTRL, 8'h03);
    foreach (srcs[i]) begin
      one = 8'h01 << srcs[i];
      periph_irq_req <= one;
      bus_write(irc_pkg::OFF_PIE, one);
      repeat (3) @(posedge clk);
      chk({31'h0, core_irq}, 32'h1, "source passed");
      bus_write(irc_pkg::OFF_PIE, 8'hf7 & ~one);
      repeat (3) @(posedge clk);
      chk({31'h0, core_irq}, 32'h0, "source masked");
    end
    periph_irq_req <= 8'h08;
    bus_write(irc_pkg::OFF_PIE, 8'hff);
    repeat (3) @(posedge clk);
    chk({31'h0, core_irq}, 32'h0, "bit three has no enable");
    periph_irq_req <= 8'hff;
    bus_write(irc_pkg::OFF_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    chk({31'h0, core_irq}, 32'h0, "group gate off");
    bus_write(irc_pkg::OFF_CTRL, 8'h02);
    repeat (3) @(posedge clk);
    chk({31'h0, core_irq}, 32'h0, "global gate off");
    bus_write(irc_pkg::OFF_CTRL, 8'h03);
    repeat (3) @(posedge clk);
    chk({31'h0, core_irq}, 32'h1, "all gates on");
    read_chk(irc_pkg::OFF_CTRL, 32'h00000003, "gates read back");
    read_chk(irc_pkg::OFF_PEND, 32'h000000f7, "pending sources");
    periph_irq_req <= 8'h00;
    bus_write(irc_pkg::OFF_CTRL, 8'h00);
  endtask : test_masking

  task automatic test_power_ctrl();
    bus_write(irc_pkg::OFF_PWR, 8'hff);
    read_chk(irc_pkg::OFF_PWR, 32'h0000000b, "power ctrl all ones");
    bus_write(irc_pkg::OFF_PWR, 8'h00);
    read_chk(irc_pkg::OFF_PWR, 32'h00000000, "power ctrl zeros");
    repeat (2) @(posedge clk);
    chk({31'h0, osc_speed_select}, 32'h0, "speed slow");
    chk({30'h0, osc_rate_sel}, {30'h0, irc_pkg::IRC_OSC_SLOW}, "rate slow");
    external_resistor_osc_mode <= 1'b1;
    bus_write(irc_pkg::OFF_PWR, 8'h08);
    repeat (3) @(posedge clk);
    chk({30'h0, osc_rate_sel}, {30'h0, irc_pkg::IRC_OSC_RES}, "resistor rate");
    external_resistor_osc_mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk({30'h0, osc_rate_sel}, {30'h0, irc_pkg::IRC_OSC_FAST}, "internal fast");
  endtask : test_power_ctrl

  task automatic test_causes();
    brownout_detect_enable_cfg <= 1'b1;
    bus_write(irc_pkg::OFF_CLR, 8'h07);
    bus_write(irc_pkg::OFF_EN, 8'h03);
    bus_write(irc_pkg::OFF_PWR, 8'h0b);
    pulse_pin(1'b1);
    read_chk(irc_pkg::OFF_PWR, 32'h0000000a, "brown-out clears flag only");
    bus_read(irc_pkg::OFF_STAT, rd);
    chk(rd & 32'h3, 32'h1, "brown-out event");
    chk({31'h0, irq}, 32'h1, "irq raised");
    bus_write(irc_pkg::OFF_CLR, 8'h01);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    pulse_pin(1'b0);
    read_chk(irc_pkg::OFF_PWR, 32'h0000000a, "other reset keeps flags");
    bus_read(irc_pkg::OFF_STAT, rd);
    chk(rd & 32'h3, 32'h2, "other reset event");
    chk({31'h0, irq}, 32'h1, "irq other");
    bus_write(irc_pkg::OFF_EN, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus_write(irc_pkg::OFF_CLR, 8'h07);
    // Flag is meaningless here; the bank simply keeps it
    brownout_detect_enable_cfg <= 1'b0;
    bus_write(irc_pkg::OFF_PWR, 8'h0b);
    pulse_pin(1'b1);
    read_chk(irc_pkg::OFF_PWR, 32'h0000000b, "detection off");
    bus_read(irc_pkg::OFF_STAT, rd);
    chk(rd & 32'h1, 32'h0, "no event when off");
  endtask : test_causes

  task automatic test_second_reset();
    bus_write(irc_pkg::OFF_PIE, 8'h55);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    read_chk(irc_pkg::OFF_PWR, 32'h00000008, "power-on again");
    read_chk(irc_pkg::OFF_PIE, 32'h00000000, "enables cleared");
  endtask : test_second_reset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h00000000;
    periph_irq_req = 8'h00;
    brownout_reset_pin = 1'b0;
    other_reset_pin = 1'b0;
    brownout_detect_enable_cfg = 1'b0;
    external_resistor_osc_mode = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    test_reset_values();
    test_enable_bits();
    test_masking();
    test_power_ctrl();
    test_causes();
    test_second_reset();
    end_sim();
  end
endmodule : testbench
